/* rtl/ext_fb_hybrid_error.sv */
// Purpose: External scale feedback decode and hybrid error check
// Assumes: All inputs synchronous to ref_clk_in, settings held steady
// Notes:   Error is kept as motor*den - scale*num, avoiding division
`timescale 1ns/1ps
`include "ext_fb_defs.svh"

module ext_fb_hybrid_error
   import ext_fb_pkg::*;
(
   input  wire logic                        ref_clk_in,                // System clock
   input  wire logic                        rstn_in,                   // Sync reset, low
   input  wire logic [3:0]                  control_mode_select_in,    // Control mode
   input  wire logic [1:0]                  scale_type_select_in,      // Scale type
   input  wire logic                        scale_direction_reverse_in, // Reverse count
   input  wire logic [`EXT_FB_RATIO_W-1:0]  scale_ratio_numerator_in,  // Ratio numerator
   input  wire logic [`EXT_FB_RATIO_W-1:0]  scale_ratio_denominator_in, // Ratio denom
   input  wire logic [`EXT_FB_LIMIT_W-1:0]  hybrid_error_limit_in,     // Overflow level
   input  wire logic [`EXT_FB_ROT_W-1:0]    hybrid_clear_rotations_in, // Clear period
   input  wire logic [`EXT_FB_RATIO_W-1:0]  motor_resolution_in,       // Counts per rev
   input  wire logic signed [`EXT_FB_DELTA_W-1:0] motor_delta_in,      // Motor change
   input  wire logic                        scale_phase_a_in,          // Quadrature A
   input  wire logic                        scale_phase_b_in,          // Quadrature B
   input  wire logic                        serial_delta_valid_in,     // Serial word valid
   input  wire logic signed [`EXT_FB_DELTA_W-1:0] serial_delta_in,     // Serial change
   input  wire logic [`EXT_FB_SPEED_W-1:0]  motor_speed_in,            // Shaft speed
   input  wire logic [`EXT_FB_SPEED_W-1:0]  motor_speed_max_in,        // Maximum speed
   output logic signed [31:0]               scale_count_out,           // Scale position
   output logic signed [`EXT_FB_ACC_W-1:0]  hybrid_error_out,          // Error times den
   output logic                             hybrid_alarm_out,          // Latched alarm
   output logic                             overspeed_error_out,       // Latched overspeed
   output logic                             hybrid_clear_out,          // Clear pulse
   output logic                             active_out                 // Checking enabled
);
   // Operating state
   fb_state_t                         state_q;        // Current state
   fb_state_t                         state_d;        // Next state
   logic                              mode_on;        // Fully-closed selected

   // Decoded scale change
   logic                              quad_up;        // Quadrature step up
   logic                              quad_down;      // Quadrature step down
   delta_t                            scale_raw;      // Change before reversal
   delta_t                            scale_delta_q;  // Registered scale change
   delta_t                            motor_delta_q;  // Registered motor change

   // Ratio terms
   logic [`EXT_FB_RATIO_W-1:0]        num_eff;        // Effective numerator
   logic [`EXT_FB_RATIO_W-1:0]        den_eff;        // Effective denominator
   logic signed [`EXT_FB_PROD_W-1:0]  motor_term;     // Motor times denominator
   logic signed [`EXT_FB_PROD_W-1:0]  scale_term;     // Scale times numerator
   logic [`EXT_FB_ACC_W-1:0]          limit_scaled_q; // Level times denominator

   // Hybrid error
   acc_t                              err_q;          // Accumulated error
   acc_t                              err_next;       // Error after this cycle
   logic [`EXT_FB_ACC_W-1:0]          err_mag;        // Magnitude of error
   logic                              over_limit;     // Magnitude above level

   // Rotation tracking
   logic signed [`EXT_FB_REV_W-1:0]   rev_pos_q;      // Travel within one rev
   logic signed [`EXT_FB_REV_W-1:0]   rev_next;       // Travel after this cycle
   logic signed [`EXT_FB_REV_W-1:0]   res_s;          // Resolution, signed
   logic                              rev_done;       // A full rev completed
   logic [`EXT_FB_ROT_W-1:0]          rot_cnt_q;      // Completed revs
   logic                              clear_now;      // Clear error this cycle

   assign mode_on = (control_mode_select_in == `EXT_FB_MODE_FULLY_CLOSED);

   // Two-phase decoder, one step per edge of either phase
   quad_decoder u_quad (
      .ref_clk_in (ref_clk_in),
      .rstn_in    (rstn_in),
      .phase_a_in (scale_phase_a_in),
      .phase_b_in (scale_phase_b_in),
      .up_out     (quad_up),
      .down_out   (quad_down)
   );

   // Pick the source by scale type
   always_comb begin
      case (scale_type_select_in)
         `EXT_FB_TYPE_QUAD: begin
            // One count per edge, so 4 Mpps is far below the clock
            scale_raw = quad_up ? 8'sh01 : (quad_down ? -8'sh01 : 8'sh00);
         end
         `EXT_FB_TYPE_SERIAL: begin
            // Whole change word per cycle covers 400 Mpps at 250 MHz
            scale_raw = serial_delta_valid_in ? serial_delta_in : 8'sh00;
         end
         default: begin
            // Reserved code counts nothing
            scale_raw = 8'sh00;
         end
      endcase
   end

   // Register scale and motor changes, reversal applied here
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         scale_delta_q <= 8'sh00;
         motor_delta_q <= 8'sh00;
      end else if (mode_on) begin
         // Counter-clockwise shaft is positive after optional reversal
         scale_delta_q <= scale_direction_reverse_in ? -scale_raw : scale_raw;
         motor_delta_q <= motor_delta_in;
      end else begin
         // Outside fully-closed mode nothing is passed on
         scale_delta_q <= 8'sh00;
         motor_delta_q <= 8'sh00;
      end
   end

   // Scale position follows the corrected change
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         scale_count_out <= `EXT_FB_COUNT_RST;
      end else begin
         scale_count_out <= scale_count_out + 32'(scale_delta_q);
      end
   end

   // Effective ratio terms
   always_comb begin
      // Zero numerator means motor resolution
      num_eff = (scale_ratio_numerator_in == '0) ? motor_resolution_in
                                                 : scale_ratio_numerator_in;
      // Denominator of zero is illegal, held at one for safety
      den_eff = (scale_ratio_denominator_in == '0) ? 21'h000001
                                                   : scale_ratio_denominator_in;
   end

   // Motor change weighted by the denominator
   ratio_scaler u_motor_scale (
      .delta_in    (motor_delta_q),
      .factor_in   (den_eff),
      .product_out (motor_term)
   );

   // Scale change weighted by the numerator
   ratio_scaler u_scale_scale (
      .delta_in    (scale_delta_q),
      .factor_in   (num_eff),
      .product_out (scale_term)
   );

   // Level kept in the same units as the accumulator
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         limit_scaled_q <= `EXT_FB_ACC_RST;
      end else begin
         // Command units taken as motor encoder counts
         limit_scaled_q <= `EXT_FB_ACC_W'(hybrid_error_limit_in * den_eff);
      end
   end

   // Rotation detection on motor travel
   always_comb begin
      res_s    = `EXT_FB_REV_W'(motor_resolution_in);
      rev_next = rev_pos_q + `EXT_FB_REV_W'(motor_delta_q);
      // Either direction of travel counts as rotation
      rev_done = (res_s != '0) && ((rev_next >= res_s) || (rev_next <= -res_s));
      // Clear fires when the programmed count is reached
      clear_now = rev_done && (hybrid_clear_rotations_in != '0) &&
                  (rot_cnt_q + 7'h01 >= hybrid_clear_rotations_in);
   end

   // Travel within the current rotation
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         rev_pos_q <= `EXT_FB_REV_RST;
      end else if (!mode_on) begin
         rev_pos_q <= `EXT_FB_REV_RST;
      end else if (rev_done) begin
         // Keep the overshoot so no counts are lost
         rev_pos_q <= (rev_next >= res_s) ? rev_next - res_s : rev_next + res_s;
      end else begin
         rev_pos_q <= rev_next;
      end
   end

   // Rotations since the last clear
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         rot_cnt_q <= `EXT_FB_ROT_RST;
      end else if (!mode_on || clear_now) begin
         rot_cnt_q <= `EXT_FB_ROT_RST;
      end else if (rev_done && hybrid_clear_rotations_in != '0) begin
         rot_cnt_q <= rot_cnt_q + 7'h01;
      end
   end

   // Next error value and the magnitude of the current error
   always_comb begin
      err_next   = err_q + `EXT_FB_ACC_W'(motor_term) - `EXT_FB_ACC_W'(scale_term);
      err_mag    = err_q[`EXT_FB_ACC_W-1] ? `EXT_FB_ACC_W'(-err_q) : `EXT_FB_ACC_W'(err_q);
      over_limit = (err_mag > limit_scaled_q);
   end

   // Hybrid error accumulator
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         err_q <= `EXT_FB_ACC_RST;
      end else if (!mode_on) begin
         err_q <= `EXT_FB_ACC_RST;
      end else if (clear_now) begin
         // Clearing drops this cycle's change as well
         err_q <= `EXT_FB_ACC_RST;
      end else begin
         err_q <= err_next;
      end
   end

   // Error shown outward, one cycle behind the accumulator
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         hybrid_error_out <= `EXT_FB_ACC_RST;
         hybrid_clear_out <= 1'b0;
      end else begin
         hybrid_error_out <= err_q;
         hybrid_clear_out <= clear_now;
      end
   end

   // State transitions
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            // Start tracking once fully-closed is chosen
            if (mode_on) begin
               state_d = ST_TRACK;
            end
         end
         ST_TRACK: begin
            if (!mode_on) begin
               state_d = ST_OFF;
            end else if (over_limit) begin
               state_d = ST_ALARM;
            end
         end
         ST_ALARM: begin
            // Only reset leaves this state
            state_d = ST_ALARM;
         end
         default: begin
            state_d = ST_OFF;
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         state_q <= ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // Alarm and activity outputs
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         hybrid_alarm_out <= 1'b0;
         active_out       <= 1'b0;
      end else begin
         hybrid_alarm_out <= (state_d == ST_ALARM);
         active_out       <= mode_on;
      end
   end

   // Overspeed is judged on the shaft, not on feedback rate
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         overspeed_error_out <= 1'b0;
      end else if (motor_speed_in > motor_speed_max_in) begin
         overspeed_error_out <= 1'b1;
      end
   end
endmodule // ext_fb_hybrid_error

/* shared/ext_fb_defs.svh */
// Purpose: Constants for the external feedback hybrid error block
// Assumes: One 250 MHz clock, synchronous active-low reset
// Notes:   Definitions only, no logic
`ifndef EXT_FB_DEFS_SVH
`define EXT_FB_DEFS_SVH

// Control mode value that enables fully-closed operation
`define EXT_FB_MODE_FULLY_CLOSED 4'h6
// Scale type codes
`define EXT_FB_TYPE_QUAD         2'h0
`define EXT_FB_TYPE_SERIAL       2'h1
`define EXT_FB_TYPE_RESERVED     2'h2
// Field widths
`define EXT_FB_RATIO_W           21
`define EXT_FB_LIMIT_W           28
`define EXT_FB_ROT_W             7
`define EXT_FB_DELTA_W           8
`define EXT_FB_PROD_W            30
`define EXT_FB_ACC_W             56
`define EXT_FB_REV_W             24
`define EXT_FB_SPEED_W           16
// Reset values
`define EXT_FB_ACC_RST           56'h0
`define EXT_FB_ROT_RST           7'h0
`define EXT_FB_REV_RST           24'h0
`define EXT_FB_COUNT_RST         32'h0

`endif

/* shared/ext_fb_pkg.sv */
// Purpose: Types for the external feedback hybrid error block
// Assumes: Widths match ext_fb_defs.svh
// Notes:   Types only
`include "ext_fb_defs.svh"

package ext_fb_pkg;
   // Signed count change per clock
   typedef logic signed [`EXT_FB_DELTA_W-1:0] delta_t;
   // Signed hybrid error accumulator
   typedef logic signed [`EXT_FB_ACC_W-1:0]   acc_t;
   // Operating state of the checker
   typedef enum logic [1:0] {
      ST_OFF,
      ST_TRACK,
      ST_ALARM
   } fb_state_t;
endpackage

/* rtl/quad_decoder.sv */
// Purpose: Times-four decoder for two-phase scale pulses
// Assumes: Phases synchronous to the clock
// Notes:   A double step between samples is dropped as invalid
`timescale 1ns/1ps
`include "ext_fb_defs.svh"

module quad_decoder (
   input  wire logic ref_clk_in,   // System clock
   input  wire logic rstn_in,      // Synchronous reset, active low
   input  wire logic phase_a_in,   // Scale phase A
   input  wire logic phase_b_in,   // Scale phase B
   output logic      up_out,       // One-cycle count-up pulse
   output logic      down_out      // One-cycle count-down pulse
);
   logic       a_q;                // Previous phase A
   logic       b_q;                // Previous phase B
   logic       moved;              // Exactly one phase changed
   logic       fwd;                // Direction of that change

   assign moved = (a_q ^ phase_a_in) ^ (b_q ^ phase_b_in);
   assign fwd   = b_q ^ phase_a_in;

   // Remember last phase pair
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
      end else begin
         a_q <= phase_a_in;
         b_q <= phase_b_in;
      end
   end

   // Every edge of either phase gives one step, unless both phases change together
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         up_out   <= 1'b0;
         down_out <= 1'b0;
      end else begin
         up_out   <= moved & fwd;
         down_out <= moved & ~fwd;
      end
   end
endmodule // quad_decoder

/* rtl/ratio_scaler.sv */
// Purpose: Signed count change times an unsigned ratio factor
// Assumes: Factor below 2^21
// Notes:   Combinational, sized to avoid overflow
`timescale 1ns/1ps
`include "ext_fb_defs.svh"

module ratio_scaler (
   input  wire logic signed [`EXT_FB_DELTA_W-1:0] delta_in,    // Count change
   input  wire logic        [`EXT_FB_RATIO_W-1:0] factor_in,   // Ratio factor
   output logic      signed [`EXT_FB_PROD_W-1:0]  product_out  // Weighted change
);
   logic signed [`EXT_FB_RATIO_W:0] factor_s;   // Factor as positive signed

   assign factor_s    = {1'b0, factor_in};
   assign product_out = `EXT_FB_PROD_W'(delta_in * factor_s);
endmodule // ratio_scaler

/* sim/ext_fb_hybrid_error_asserts.sv */
// Purpose: Port-level assertions for the hybrid error block
// Assumes: Settings held steady between resets
// Notes:   Bound to every ext_fb_hybrid_error instance
`timescale 1ns/1ps
`include "ext_fb_defs.svh"

module ext_fb_hybrid_error_chk (
   input wire logic                        ref_clk_in,                 // Clock
   input wire logic                        rstn_in,                    // Reset, low
   input wire logic [3:0]                  control_mode_select_in,     // Mode
   input wire logic [`EXT_FB_RATIO_W-1:0]  scale_ratio_denominator_in, // Denominator
   input wire logic [`EXT_FB_LIMIT_W-1:0]  hybrid_error_limit_in,      // Level
   input wire logic [`EXT_FB_ROT_W-1:0]    hybrid_clear_rotations_in,  // Clear period
   input wire logic [`EXT_FB_SPEED_W-1:0]  motor_speed_in,             // Speed
   input wire logic [`EXT_FB_SPEED_W-1:0]  motor_speed_max_in,         // Max speed
   input wire logic signed [31:0]          scale_count_out,            // Scale count
   input wire logic signed [`EXT_FB_ACC_W-1:0] hybrid_error_out,       // Error
   input wire logic                        hybrid_alarm_out,           // Alarm
   input wire logic                        overspeed_error_out,        // Overspeed
   input wire logic                        hybrid_clear_out,           // Clear pulse
   input wire logic                        active_out                  // Active
);
   logic [55:0] mag_w;   // Error magnitude
   logic [55:0] lim_w;   // Level scaled by denominator, zero read as one
   assign mag_w = hybrid_error_out[55] ? 56'(-hybrid_error_out) : 56'(hybrid_error_out);
   assign lim_w = 56'(hybrid_error_limit_in) * ((scale_ratio_denominator_in == 21'h0) ?
                  56'h1 : 56'(scale_ratio_denominator_in));

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);

   alarm_hold_a: assert property (hybrid_alarm_out |=> hybrid_alarm_out)
      else $error("hybrid alarm dropped");
   alarm_cause_a: assert property ($rose(hybrid_alarm_out) |-> mag_w > lim_w)
      else $error("hybrid alarm without excess");
   alarm_raise_a: assert property (active_out && mag_w > lim_w |-> hybrid_alarm_out)
      else $error("excess error without alarm");
   speed_hold_a: assert property (overspeed_error_out |=> overspeed_error_out)
      else $error("overspeed dropped");
   speed_raise_a: assert property (control_mode_select_in == `EXT_FB_MODE_FULLY_CLOSED &&
      motor_speed_in > motor_speed_max_in |-> ##[1:3] overspeed_error_out)
      else $error("overspeed not raised");
   mode_idle_a: assert property ((control_mode_select_in != 4'h6) [*3] |->
      hybrid_error_out == 0 && !active_out && $stable(scale_count_out))
      else $error("activity outside fully-closed mode");
   clear_pulse_a: assert property (hybrid_clear_out |=> !hybrid_clear_out)
      else $error("clear pulse too long");
   clear_zero_a: assert property (hybrid_clear_out |-> ##[0:1] hybrid_error_out == 0)
      else $error("error not zero after clear");
   clear_off_a: assert property (hybrid_clear_rotations_in == 7'h0 |-> !hybrid_clear_out)
      else $error("clear while disabled");
endmodule // ext_fb_hybrid_error_chk

bind ext_fb_hybrid_error ext_fb_hybrid_error_chk chk_u (.ref_clk_in, .rstn_in,
   .control_mode_select_in, .scale_ratio_denominator_in, .hybrid_error_limit_in,
   .hybrid_clear_rotations_in, .motor_speed_in, .motor_speed_max_in, .scale_count_out,
   .hybrid_error_out, .hybrid_alarm_out, .overspeed_error_out, .hybrid_clear_out, .active_out);

/* sim/scale_model.sv */
// Purpose: Linear scale model, two-phase pulses and serial words
// Assumes: Driven at the falling clock edge
// Notes:   Stale serial data is inverted so it never repeats
`timescale 1ns/1ps

module scale_model (
   input  wire logic        ref_clk_in,  // Clock
   output logic             phase_a_out, // Phase A
   output logic             phase_b_out, // Phase B
   output logic             valid_out,   // Serial word valid
   output logic signed [7:0] data_out    // Serial word
);
   // Idle lines at time zero
   initial begin
      phase_a_out = 1'b0;
      phase_b_out = 1'b0;
      valid_out = 1'b0;
      data_out = 8'h00;
   end

   // Signed count of edges; up means A leads B, one phase at a time
   task automatic quad(input int n);
      for (int i = 0; i < (n < 0 ? -n : n); i++) begin
         repeat (3) @(negedge ref_clk_in);
         if (n > 0) {phase_a_out, phase_b_out} = {~phase_b_out, phase_a_out};
         else {phase_a_out, phase_b_out} = {phase_b_out, ~phase_a_out};
      end
   endtask

   // One serial word for one cycle
   task automatic ser(input logic signed [7:0] v);
      @(negedge ref_clk_in);
      valid_out = 1'b1;
      data_out = v;
      @(negedge ref_clk_in);
      valid_out = 1'b0;
      data_out = ~v;
   endtask
endmodule // scale_model

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the hybrid error block
// Assumes: Inputs change at the falling edge
// Notes:   Error output is scaled by the denominator
`timescale 1ns/1ps
`include "ext_fb_defs.svh"

module tb_top;
   logic ref_clk_in, rstn_in, scale_direction_reverse_in; // Clock, reset, reversal
   logic [3:0] control_mode_select_in;                   // Mode
   logic [1:0] scale_type_select_in;                     // Scale type
   logic [20:0] scale_ratio_numerator_in, scale_ratio_denominator_in, motor_resolution_in;
   logic [27:0] hybrid_error_limit_in;                   // Level
   logic [6:0] hybrid_clear_rotations_in;                // Clear period
   logic signed [7:0] motor_delta_in, serial_delta_in;   // Deltas
   logic scale_phase_a_in, scale_phase_b_in, serial_delta_valid_in; // From model
   logic [15:0] motor_speed_in, motor_speed_max_in;      // Speeds
   logic signed [31:0] scale_count_out;                  // Scale count
   logic signed [55:0] hybrid_error_out;                 // Error
   logic hybrid_alarm_out, overspeed_error_out, hybrid_clear_out, active_out; // Flags
   int fail_count = 0;                                   // Mismatches
   int cmp_count = 0;                                    // Comparisons

   ext_fb_hybrid_error dut_u (.ref_clk_in, .rstn_in, .control_mode_select_in,
      .scale_type_select_in, .scale_direction_reverse_in, .scale_ratio_numerator_in,
      .scale_ratio_denominator_in, .hybrid_error_limit_in, .hybrid_clear_rotations_in,
      .motor_resolution_in, .motor_delta_in, .scale_phase_a_in, .scale_phase_b_in,
      .serial_delta_valid_in, .serial_delta_in, .motor_speed_in, .motor_speed_max_in,
      .scale_count_out, .hybrid_error_out, .hybrid_alarm_out, .overspeed_error_out,
      .hybrid_clear_out, .active_out);
   scale_model sm_u (.ref_clk_in, .phase_a_out(scale_phase_a_in),
      .phase_b_out(scale_phase_b_in), .valid_out(serial_delta_valid_in),
      .data_out(serial_delta_in));

   // Clock
   initial begin
      ref_clk_in = 1'b0;
      forever #2 ref_clk_in = ~ref_clk_in;
   end

   // Compare one value
   task automatic chk(input string nm, input logic [55:0] exp, input logic [55:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   // Reset with new settings; reserved type never used
   task automatic cfg(input logic [3:0] m, input logic [1:0] t, input logic r,
      input logic [20:0] n, input logic [20:0] d, input logic [27:0] l, input logic [6:0] c);
      @(negedge ref_clk_in);
      rstn_in = 1'b0;
      {control_mode_select_in, scale_type_select_in, scale_direction_reverse_in} = {m, t, r};
      {scale_ratio_numerator_in, scale_ratio_denominator_in} = {n, d};
      {hybrid_error_limit_in, hybrid_clear_rotations_in} = {l, c};
      repeat (4) @(negedge ref_clk_in);
      rstn_in = 1'b1;
      repeat (2) @(negedge ref_clk_in);
   endtask

   // Motor change for n cycles, then settle
   task automatic mov(input logic signed [7:0] v, input int n);
      motor_delta_in = v;
      repeat (n) @(negedge ref_clk_in);
      motor_delta_in = 8'h00;
      repeat (6) @(negedge ref_clk_in);
   endtask

   // Quadrature counting, serial words ignored
   task automatic t_quad(input logic r);
      cfg(4'h6, 2'h0, r, 21'h1, 21'h1, 28'h100, 7'h0);
      sm_u.quad(4);
      sm_u.ser(8'sh09);
      repeat (6) @(negedge ref_clk_in);
      chk("count", r ? -56'sh4 : 56'sh4, scale_count_out);
      chk("error", r ? 56'sh4 : -56'sh4, hybrid_error_out);
      $display("quad test done");
   endtask

   // Serial counting with ratio, quadrature ignored
   task automatic t_ser(input logic r, input logic [20:0] n, input logic [20:0] d,
      input logic signed [7:0] w, input logic [55:0] ec, input logic [55:0] ee);
      cfg(4'h6, 2'h1, r, n, d, 28'h100, 7'h0);
      sm_u.ser(w);
      sm_u.quad(-4);
      repeat (6) @(negedge ref_clk_in);
      chk("count", ec, scale_count_out);
      chk("error", ee, hybrid_error_out);
      $display("serial test done");
   endtask

   // Alarm at strict excess, then latched
   task automatic t_alarm;
      cfg(4'h6, 2'h0, 1'b0, 21'h1, 21'h2, 28'h4, 7'h0);
      mov(8'sh04, 1);
      chk("error", 56'h8, hybrid_error_out);
      chk("alarm", 56'h0, hybrid_alarm_out);
      mov(8'sh01, 1);
      chk("alarm", 56'h1, hybrid_alarm_out);
      mov(-8'sh05, 1);
      chk("error", 56'h0, hybrid_error_out);
      chk("alarm", 56'h1, hybrid_alarm_out);
      $display("alarm test done");
   endtask

   // Clear after two rotations, none when disabled
   task automatic t_clear(input logic [6:0] c);
      int seen;
      seen = 0;
      cfg(4'h6, 2'h0, 1'b0, 21'h1, 21'h1, 28'h1000, c);
      motor_delta_in = 8'sh04;
      for (int i = 0; i < 24; i++) begin
         @(negedge ref_clk_in);
         if (i == 7) motor_delta_in = 8'h00;
         if (hybrid_clear_out === 1'b1) seen++;
      end
      chk("clears", c ? 56'h1 : 56'h0, 56'(seen));
      chk("error", c ? 56'h0 : 56'sh20, hybrid_error_out);
      $display("clear test done");
   endtask

   // Other mode ignores scale and motor changes; speed compare in mode 6
   task automatic t_mode;
      cfg(4'h0, 2'h1, 1'b0, 21'h1, 21'h1, 28'h1, 7'h0);
      sm_u.ser(8'sh03);
      mov(8'sh05, 2);
      chk("count", 56'h0, scale_count_out);
      chk("error", 56'h0, hybrid_error_out);
      chk("active", 56'h0, active_out);
      cfg(4'h6, 2'h0, 1'b0, 21'h1, 21'h1, 28'h100, 7'h0);
      chk("active", 56'h1, active_out);
      motor_speed_in = 16'h0032;
      mov(8'h00, 1);
      chk("overspeed", 56'h0, overspeed_error_out);
      motor_speed_in = 16'h0033;
      mov(8'h00, 1);
      motor_speed_in = 16'h0000;
      mov(8'h00, 1);
      chk("overspeed", 56'h1, overspeed_error_out);
      $display("mode test done");
   endtask

   // Verdict
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (6000) @(posedge ref_clk_in);
      fail_count++;
      stop_test();
   end

   // Main sequence
   initial begin
      rstn_in = 1'b0;
      {control_mode_select_in, scale_type_select_in, scale_direction_reverse_in} = 7'h0;
      {scale_ratio_numerator_in, scale_ratio_denominator_in} = {21'h1, 21'h1};
      {hybrid_error_limit_in, hybrid_clear_rotations_in} = {28'h1, 7'h0};
      motor_resolution_in = 21'h10;
      motor_delta_in = 8'h00;
      motor_speed_in = 16'h0000;
      motor_speed_max_in = 16'h0032;
      t_quad(1'b0);
      t_quad(1'b1);
      t_ser(1'b0, 21'h3, 21'h2, 8'sh07, 56'h7, -56'sh15);
      t_ser(1'b0, 21'h0, 21'h1, 8'sh02, 56'h2, -56'sh20);
      t_ser(1'b1, 21'h1, 21'h1, -8'sh03, 56'h3, -56'sh3);
      t_alarm();
      t_clear(7'h2);
      t_clear(7'h0);
      t_mode();
      stop_test();
   end
endmodule // tb_top
